// File: pkg/ddm_pkg.sv
/*
  Shared constants, types and geometry functions for the dual channel
  DDR2 address mapper. Assumes one 50 MHz clock and the unit of one
  aligned 64-byte cache line on the host side.
*/
// Functional notes
// - Two independent channels, 64-bit data each, one DIMM per channel.
// - Only unbuffered non-ECC modules, one per channel; no check bits made.
// - One populated channel gives single mode; all cycles go there.
// - Symmetric mode alternates channel on every 64-byte line boundary.
// - Symmetric: request to the other channel issues before first data returns.
// - Symmetric: two consecutive lines may be fetched together, one per channel.
// - Equal channel capacity picks symmetric, whatever device width or density.
// - Asymmetric: linear through channel 0 top, then channel 1 from bottom.
// - Both populated with different capacities picks asymmetric mode.
// - Each channel runs at 667 or 800 MT/s.
// - Devices of 512 Mb or 1 Gb, organised x8 or x16.
// - x16: 13 row, 10 col; x8: 14/10; 4 or 8 banks; 8K page.
// - Single sided is one rank, double sided x8 two; two ranks max.
package ddm_pkg;

  // ************************************************************
  // Widths and address layout
  // ************************************************************
  localparam int ADDR_W = 32;
  localparam int CAP_W = 33;
  localparam int LOC_W = 31;
  localparam int DQ_W = 64;
  localparam int LINE_BIT = 6;
  localparam int LINE_BYTES = 64;
  localparam int BEAT_BITS = 3;
  localparam int COL_BITS = 10;
  localparam int ROW_MAX = 14;
  localparam int BANK_MAX = 3;
  localparam int RANK_MAX = 2;
  localparam int PAGE_BYTES = 8192;
  localparam logic [3:0] ROW_X16 = 4'hD;
  localparam logic [3:0] ROW_X8 = 4'hE;
  localparam logic [1:0] BANK_512 = 2'h2;
  localparam logic [1:0] BANK_1G = 2'h3;
  localparam int RATE_667 = 667;
  localparam int RATE_800 = 800;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'h1,
    MODE_SYM = 3'h2,
    MODE_ASYM = 3'h4
  } ddm_mode_type;

  typedef enum logic [2:0] {
    ST_CFG = 3'h1,
    ST_RUN = 3'h2,
    ST_FAULT = 3'h4
  } ddm_state_type;

  // ************************************************************
  // Geometry functions
  // ************************************************************
  // Row bits from device width
  function automatic logic [3:0] ddm_row_bits(input logic x16);
    return x16 ? ROW_X16 : ROW_X8;
  endfunction

  // Bank select bits from density: 4 banks or 8 banks
  function automatic logic [1:0] ddm_bank_bits(input logic dens_1g);
    return dens_1g ? BANK_1G : BANK_512;
  endfunction

  // Bytes in one channel: rank size times rank count
  function automatic logic [CAP_W-1:0] ddm_chan_cap(input logic pres,
      input logic x16, input logic dens_1g, input logic dual);
    logic [5:0] sh;
    logic [CAP_W-1:0] rank;
    sh = 6'(BEAT_BITS + COL_BITS) + 6'(ddm_bank_bits(dens_1g))
      + 6'(ddm_row_bits(x16));
    rank = CAP_W'(1) << sh;
    if (!pres) begin
      return '0;
    end
    return dual ? (rank << 1) : rank;
  endfunction

endpackage

// File: src/ddm_addr_split.sv
/*
  Splits a channel-local byte address into column, bank, row and rank
  fields for one DIMM. Purely combinational; the geometry inputs are
  expected to stay still while traffic runs.
*/
`timescale 1ns/10ps
module ddm_addr_split
  import ddm_pkg::*;
(
  input wire logic [ddm_pkg::LOC_W-1:0] local_addr,
  input wire logic x16,
  input wire logic dens_1g,
  output logic [ddm_pkg::COL_BITS-1:0] col,
  output logic [ddm_pkg::BANK_MAX-1:0] bank,
  output logic [ddm_pkg::ROW_MAX-1:0] row,
  output logic rank
);

  // ************************************************************
  // Field extraction
  // ************************************************************
  // Bank sits right above the 8K page, row above bank, rank on top
  always_comb begin
    logic [LOC_W-1:0] upper;
    logic [LOC_W-1:0] above_bank;
    upper = local_addr >> (BEAT_BITS + COL_BITS);
    above_bank = upper >> ddm_bank_bits(dens_1g);
    col = local_addr[BEAT_BITS +: COL_BITS];
    bank = upper[BANK_MAX-1:0]
      & BANK_MAX'((4'h1 << ddm_bank_bits(dens_1g)) - 4'h1);
    row = above_bank[ROW_MAX-1:0]
      & ROW_MAX'((15'h1 << ddm_row_bits(x16)) - 15'h1);
    rank = above_bank[ddm_row_bits(x16)];
  end

endmodule

// File: src/ddm_chan_slot.sv
/*
  One command holding slot for a single DDR2 channel. Assumes the
  channel sequencer takes a command with valid and ready on one clock.
*/
`timescale 1ns/10ps
module ddm_chan_slot
  import ddm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [ddm_pkg::COL_BITS-1:0] col,
  input wire logic [ddm_pkg::BANK_MAX-1:0] bank,
  input wire logic [ddm_pkg::ROW_MAX-1:0] row,
  input wire logic rank,
  input wire logic write,
  input wire logic cmd_ready,
  output logic cmd_valid_ff,
  output logic [ddm_pkg::COL_BITS-1:0] col_ff,
  output logic [ddm_pkg::BANK_MAX-1:0] bank_ff,
  output logic [ddm_pkg::ROW_MAX-1:0] row_ff,
  output logic rank_ff,
  output logic write_ff
);

  // ************************************************************
  // Slot state
  // ************************************************************
  // Load only lands on an empty slot; the mapper guarantees that
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_valid_ff <= 1'b0;
    end else if (load) begin
      cmd_valid_ff <= 1'b1;
    end else if (cmd_ready) begin
      cmd_valid_ff <= 1'b0;
    end
  end

  // Fields held while waiting, so a stalled channel sees no change
  always_ff @(posedge clk) begin
    if (srst) begin
      col_ff <= '0;
      bank_ff <= '0;
      row_ff <= '0;
      rank_ff <= 1'b0;
      write_ff <= 1'b0;
    end else if (load) begin
      col_ff <= col;
      bank_ff <= bank;
      row_ff <= row;
      rank_ff <= rank;
      write_ff <= write;
    end
  end

  property p_slot_hold;
    @(posedge clk) disable iff (srst)
      cmd_valid_ff && !cmd_ready |=> cmd_valid_ff && $stable(row_ff)
        && $stable(col_ff) && $stable(bank_ff);
  endproperty
  a_slot_hold: assert property (p_slot_hold)
    else $error("channel command changed while stalled");

endmodule

// File: src/ddm_mapper.sv
/*
  Dual channel DDR2 address mapper: fixes the organisation mode at
  initialisation from channel population and routes each cache-line
  request to a channel with row, bank, column and rank. Assumes the
  population inputs come from logic on the same clock and are stable
  when cfg_lock pulses.
*/
`timescale 1ns/10ps
module ddm_mapper
  import ddm_pkg::*;
#(
  parameter int LINE_SIZE = 64
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cfg_lock,
  input wire logic [1:0] ch_present,
  input wire logic [1:0] ch_x16,
  input wire logic [1:0] ch_dens_1g,
  input wire logic [1:0] ch_dual_rank,
  input wire logic [1:0] ch_ecc_or_reg,
  input wire logic [1:0] ch_rate_800,
  input wire logic req_valid,
  input wire logic [ddm_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_write,
  input wire logic ch0_cmd_ready,
  input wire logic ch1_cmd_ready,
  output logic req_ack_ff,
  output logic addr_err_ff,
  output logic cfg_done_ff,
  output logic cfg_fault_ff,
  output ddm_pkg::ddm_mode_type mode_ff,
  output logic [1:0] rate_800_ff,
  output logic ch0_cmd_valid_ff,
  output logic [ddm_pkg::COL_BITS-1:0] ch0_col_ff,
  output logic [ddm_pkg::BANK_MAX-1:0] ch0_bank_ff,
  output logic [ddm_pkg::ROW_MAX-1:0] ch0_row_ff,
  output logic ch0_rank_ff,
  output logic ch0_write_ff,
  output logic ch1_cmd_valid_ff,
  output logic [ddm_pkg::COL_BITS-1:0] ch1_col_ff,
  output logic [ddm_pkg::BANK_MAX-1:0] ch1_bank_ff,
  output logic [ddm_pkg::ROW_MAX-1:0] ch1_row_ff,
  output logic ch1_rank_ff,
  output logic ch1_write_ff
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Interleave bit is fixed by the line size the host bus uses
  if (LINE_SIZE != LINE_BYTES) begin : g_bad_line
    $error("line size must match the interleave granule");
  end
  if (PAGE_BYTES != (1 << (COL_BITS + BEAT_BITS))) begin : g_bad_page
    $error("page size does not match column width");
  end

  // ************************************************************
  // Declarations
  // ************************************************************
  ddm_state_type state_ff;
  ddm_mode_type nxt_mode;
  logic single_ch_ff;
  logic [CAP_W-1:0] cap0_ff, total_ff, cap0, cap1;
  logic [1:0] x16_ff, dens_ff, load, slot_busy;
  logic cfg_bad, run, in_range, tgt, take;
  logic [LOC_W-1:0] loc;
  logic [COL_BITS-1:0] col0, col1;
  logic [BANK_MAX-1:0] bank0, bank1;
  logic [ROW_MAX-1:0] row0, row1;
  logic rank0, rank1;

  // ************************************************************
  // Population decode
  // ************************************************************
  // Capacity per channel from the detected module geometry
  assign cap0 = ddm_chan_cap(ch_present[0], ch_x16[0], ch_dens_1g[0],
    ch_dual_rank[0]);
  assign cap1 = ddm_chan_cap(ch_present[1], ch_x16[1], ch_dens_1g[1],
    ch_dual_rank[1]);

  // A double sided x16 card or ECC/buffered module cannot be served
  assign cfg_bad = (ch_present == 2'h0)
    || |(ch_present & ch_x16 & ch_dual_rank)
    || |(ch_present & ch_ecc_or_reg);

  // Only total size decides; width and density may differ
  always_comb begin
    if (ch_present != 2'h3) begin
      nxt_mode = MODE_SINGLE;
    end else if (cap0 == cap1) begin
      nxt_mode = MODE_SYM;
    end else begin
      nxt_mode = MODE_ASYM;
    end
  end

  // ************************************************************
  // Configuration state
  // ************************************************************
  // Mode locks once; only a reset may change it while traffic runs
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_CFG;
    end else begin
      unique case (state_ff)
        ST_CFG: begin
          if (cfg_lock) begin
            state_ff <= cfg_bad ? ST_FAULT : ST_RUN;
          end
        end
        ST_RUN: begin
          state_ff <= ST_RUN;
        end
        default: begin
          state_ff <= ST_FAULT;
        end
      endcase
    end
  end

  // Latched organisation, geometry and link rate
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_ff <= MODE_SINGLE;
      single_ch_ff <= 1'b0;
      cap0_ff <= '0;
      total_ff <= '0;
      x16_ff <= 2'h0;
      dens_ff <= 2'h0;
      rate_800_ff <= 2'h0;
    end else if (state_ff == ST_CFG && cfg_lock) begin
      mode_ff <= nxt_mode;
      single_ch_ff <= !ch_present[0];
      cap0_ff <= cap0;
      total_ff <= CAP_W'(cap0 + cap1);
      x16_ff <= ch_x16;
      dens_ff <= ch_dens_1g;
      rate_800_ff <= ch_rate_800;
    end
  end

  // Status flags follow the state directly
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_done_ff <= 1'b0;
      cfg_fault_ff <= 1'b0;
    end else begin
      cfg_done_ff <= (state_ff == ST_CFG && cfg_lock && !cfg_bad)
        || state_ff == ST_RUN;
      cfg_fault_ff <= (state_ff == ST_CFG && cfg_lock && cfg_bad)
        || state_ff == ST_FAULT;
    end
  end

  // ************************************************************
  // Request routing
  // ************************************************************
  assign run = (state_ff == ST_RUN);
  assign in_range = {1'b0, req_addr} < total_ff;
  assign slot_busy = {ch1_cmd_valid_ff, ch0_cmd_valid_ff};

  // Channel choice and channel-local address per mode
  always_comb begin
    logic [CAP_W-1:0] rel;
    rel = {1'b0, req_addr} - cap0_ff;
    unique case (mode_ff)
      MODE_SINGLE: begin
        tgt = single_ch_ff;
        loc = req_addr[LOC_W-1:0];
      end
      MODE_SYM: begin
        tgt = req_addr[LINE_BIT];
        loc = {req_addr[ADDR_W-1:LINE_BIT+1], req_addr[LINE_BIT-1:0]};
      end
      MODE_ASYM: begin
        tgt = !({1'b0, req_addr} < cap0_ff);
        loc = tgt ? rel[LOC_W-1:0] : req_addr[LOC_W-1:0];
      end
    endcase
  end

  // Each slot waits on its own channel, so the other keeps taking work;
  // the blocked cycle after an ack stops a second take of one request
  assign take = req_valid && run && !req_ack_ff
    && (!in_range || !slot_busy[tgt]);
  assign load = {take && in_range && tgt, take && in_range && !tgt};

  // Handshake back to the host
  always_ff @(posedge clk) begin
    if (srst) begin
      req_ack_ff <= 1'b0;
      addr_err_ff <= 1'b0;
    end else begin
      req_ack_ff <= take;
      addr_err_ff <= take && !in_range;
    end
  end

  // ************************************************************
  // Channel instances
  // ************************************************************
  // Each channel decodes with its own device geometry
  ddm_addr_split u_split0 (
    .local_addr(loc),
    .x16(x16_ff[0]),
    .dens_1g(dens_ff[0]),
    .col(col0),
    .bank(bank0),
    .row(row0),
    .rank(rank0)
  );

  ddm_addr_split u_split1 (
    .local_addr(loc),
    .x16(x16_ff[1]),
    .dens_1g(dens_ff[1]),
    .col(col1),
    .bank(bank1),
    .row(row1),
    .rank(rank1)
  );

  // Two independent command paths, one per 64-bit channel
  ddm_chan_slot u_slot0 (
    .clk(clk),
    .srst(srst),
    .load(load[0]),
    .col(col0),
    .bank(bank0),
    .row(row0),
    .rank(rank0),
    .write(req_write),
    .cmd_ready(ch0_cmd_ready),
    .cmd_valid_ff(ch0_cmd_valid_ff),
    .col_ff(ch0_col_ff),
    .bank_ff(ch0_bank_ff),
    .row_ff(ch0_row_ff),
    .rank_ff(ch0_rank_ff),
    .write_ff(ch0_write_ff)
  );

  ddm_chan_slot u_slot1 (
    .clk(clk),
    .srst(srst),
    .load(load[1]),
    .col(col1),
    .bank(bank1),
    .row(row1),
    .rank(rank1),
    .write(req_write),
    .cmd_ready(ch1_cmd_ready),
    .cmd_valid_ff(ch1_cmd_valid_ff),
    .col_ff(ch1_col_ff),
    .bank_ff(ch1_bank_ff),
    .row_ff(ch1_row_ff),
    .rank_ff(ch1_rank_ff),
    .write_ff(ch1_write_ff)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_sym_alt;
    @(posedge clk) disable iff (srst)
      take && in_range && mode_ff == MODE_SYM
        |-> load[req_addr[LINE_BIT]] && !load[!req_addr[LINE_BIT]];
  endproperty
  a_sym_alt: assert property (p_sym_alt)
    else $error("symmetric line went to wrong channel");

  property p_single_route;
    @(posedge clk) disable iff (srst)
      load != 2'h0 && mode_ff == MODE_SINGLE
        |-> load[single_ch_ff] && !load[!single_ch_ff];
  endproperty
  a_single_route: assert property (p_single_route)
    else $error("single mode used the empty channel");

  property p_asym_low;
    @(posedge clk) disable iff (srst)
      take && mode_ff == MODE_ASYM && {1'b0, req_addr} < cap0_ff
        |-> load == 2'h1 ##1 ch0_cmd_valid_ff;
  endproperty
  a_asym_low: assert property (p_asym_low)
    else $error("low asymmetric address left channel 0");

  property p_sym_sel;
    @(posedge clk) disable iff (srst)
      state_ff == ST_CFG && cfg_lock && !cfg_bad && ch_present == 2'h3
        && cap0 == cap1 |=> mode_ff == MODE_SYM && cfg_done_ff;
  endproperty
  a_sym_sel: assert property (p_sym_sel)
    else $error("equal channels did not select symmetric");

  property p_asym_sel;
    @(posedge clk) disable iff (srst)
      state_ff == ST_CFG && cfg_lock && !cfg_bad && ch_present == 2'h3
        && cap0 != cap1 |=> mode_ff == MODE_ASYM;
  endproperty
  a_asym_sel: assert property (p_asym_sel)
    else $error("unequal channels did not select asymmetric");

  property p_mode_fixed;
    @(posedge clk) disable iff (srst)
      state_ff != ST_CFG |=> $stable(mode_ff) && state_ff != ST_CFG;
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("mode changed after initialisation");

  property p_bad_module;
    @(posedge clk) disable iff (srst)
      state_ff == ST_CFG && cfg_lock && |(ch_present & ch_ecc_or_reg)
        |=> cfg_fault_ff && !cfg_done_ff ##1 !req_ack_ff;
  endproperty
  a_bad_module: assert property (p_bad_module)
    else $error("ECC or buffered module was accepted");

  property p_other_free;
    @(posedge clk) disable iff (srst)
      req_valid && run && !req_ack_ff && in_range && !slot_busy[tgt]
        && slot_busy[!tgt] |=> req_ack_ff;
  endproperty
  a_other_free: assert property (p_other_free)
    else $error("stalled channel blocked the other one");

  property p_x16_dual;
    @(posedge clk) disable iff (srst)
      state_ff == ST_CFG && cfg_lock && |(ch_present & ch_x16 & ch_dual_rank)
        |=> state_ff == ST_FAULT;
  endproperty
  a_x16_dual: assert property (p_x16_dual)
    else $error("double sided x16 module was accepted");

endmodule

// File: test/ddm_chan_model.sv
/*
  Stand-in for the command sequencer of one DDR2 channel.
  Assumes the mapper's clock and its synchronous active-high reset.
*/
`timescale 1ns/10ps
module ddm_chan_model #(
  parameter logic [7:0] SEED = 8'h5A
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic stall,
  output logic cmd_ready_ff
);
  logic [7:0] rnd_ff;

  // ************************************************************
  // Accept timing
  // ************************************************************
  // Random accept gives prompt and slow answers; stall holds off all
  always_ff @(posedge clk) begin
    if (srst) begin
      rnd_ff <= SEED;
      cmd_ready_ff <= 1'b0;
    end else begin
      rnd_ff <= {rnd_ff[6:0], rnd_ff[7] ^ rnd_ff[5] ^ rnd_ff[4] ^ rnd_ff[3]};
      cmd_ready_ff <= cmd_valid && !stall && rnd_ff[0];
    end
  end
endmodule

// File: test/dual_channel_ddr2_address_mapper_bench.sv
/*
  Self-checking bench for the mapper: reference mapping, two channel
  stand-ins, boundary and random traffic for every accepted population kind, one refused request for each faulty one.
  Assumes the mapper package and one 50 MHz clock.
*/
`timescale 1ns/10ps
module dual_channel_ddr2_address_mapper_bench;
  import ddm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cfg_lock = 1'b0;
  logic [1:0] ch_present = 2'h0, ch_x16 = 2'h0, ch_dens_1g = 2'h0;
  logic [1:0] ch_dual_rank = 2'h0, ch_ecc_or_reg = 2'h0;
  logic [1:0] ch_rate_800 = 2'h0, stall = 2'h0;
  logic req_valid = 1'b0, req_write = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic ch0_cmd_ready, ch1_cmd_ready, req_ack_ff, addr_err_ff;
  logic cfg_done_ff, cfg_fault_ff;
  ddm_mode_type mode_ff, md;
  logic [1:0] rate_800_ff, p, x, d, r, e, rt;
  logic ch0_cmd_valid_ff, ch0_rank_ff, ch0_write_ff;
  logic ch1_cmd_valid_ff, ch1_rank_ff, ch1_write_ff;
  logic [9:0] ch0_col_ff, ch1_col_ff;
  logic [2:0] ch0_bank_ff, ch1_bank_ff;
  logic [13:0] ch0_row_ff, ch1_row_ff;
  logic [31:0] lfsr = 32'h6972;
  logic [63:0] cap [2];
  logic [63:0] tot;
  logic flt, sp;
  logic [9:0] cfgs [8] = '{10'h140, 10'h228, 10'h324, 10'h350, 10'h358,
    10'h000, 10'h302, 10'h144};
  int bad_count = 0;
  int check_count = 0;
  int n;

  ddm_mapper dut (
    .clk, .srst, .cfg_lock, .ch_present, .ch_x16, .ch_dens_1g,
    .ch_dual_rank, .ch_ecc_or_reg, .ch_rate_800, .req_valid, .req_addr,
    .req_write, .ch0_cmd_ready, .ch1_cmd_ready, .req_ack_ff, .addr_err_ff,
    .cfg_done_ff, .cfg_fault_ff, .mode_ff, .rate_800_ff, .ch0_cmd_valid_ff,
    .ch0_col_ff, .ch0_bank_ff, .ch0_row_ff, .ch0_rank_ff, .ch0_write_ff,
    .ch1_cmd_valid_ff, .ch1_col_ff, .ch1_bank_ff, .ch1_row_ff,
    .ch1_rank_ff, .ch1_write_ff
  );
  ddm_chan_model #(.SEED(8'h5A)) part0 (.clk, .srst,
    .cmd_valid(ch0_cmd_valid_ff), .stall(stall[0]),
    .cmd_ready_ff(ch0_cmd_ready));
  ddm_chan_model #(.SEED(8'hC3)) part1 (.clk, .srst,
    .cmd_valid(ch1_cmd_valid_ff), .stall(stall[1]),
    .cmd_ready_ff(ch1_cmd_ready));

  // 50 MHz clock
  always #10 clk = ~clk;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
    return lfsr;
  endfunction

  // Bytes of one module: 8-byte beats, 1K columns, banks, rows, ranks
  function automatic logic [63:0] cap_of(logic xw, logic dg, logic dr);
    return 64'h1 << (13 + (dg ? 3 : 2) + (xw ? 13 : 14) + dr);
  endfunction

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (exp !== got) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One request, held until taken; population inputs scrambled meanwhile
  task automatic req(logic [31:0] a);
    logic [63:0] loc, bk, rw, exp, got;
    logic ch, err, w;
    int b, rb;
    w = ^rnd();
    err = a >= tot;
    ch = md == MODE_SYM ? a[6] : md == MODE_ASYM ? a >= cap[0] : sp;
    loc = md == MODE_SYM ? {a[31:7], a[5:0]} :
      (ch && md == MODE_ASYM) ? a - cap[0] : a;
    b = d[ch] ? 3 : 2;
    rb = x[ch] ? 13 : 14;
    bk = (loc >> 13) & ((64'h1 << b) - 1);
    rw = (loc >> (13 + b)) & ((64'h1 << rb) - 1);
    exp = {1'b1, loc[12:3], bk[2:0], rw[13:0], loc[13 + b + rb], w};
    @(posedge clk);
    {ch_present, ch_x16, ch_dens_1g, ch_dual_rank, ch_ecc_or_reg,
      ch_rate_800} <= 12'(rnd());
    req_valid <= 1'b1;
    req_addr <= a;
    req_write <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ack_ff !== 1'b1 && n < 300);
    req_valid <= 1'b0;
    got = ch ? {ch1_cmd_valid_ff, ch1_col_ff, ch1_bank_ff, ch1_row_ff,
      ch1_rank_ff, ch1_write_ff} : {ch0_cmd_valid_ff, ch0_col_ff,
      ch0_bank_ff, ch0_row_ff, ch0_rank_ff, ch0_write_ff};
    chk("ack", 1, req_ack_ff);
    chk("range error", err, addr_err_ff);
    if (!err) begin
      chk("command", exp, got);
    end
  endtask

  // ************************************************************
  // Main sequence: one pass per channel population
  // ************************************************************
  initial begin
    foreach (cfgs[i]) begin
      {p, x, d, r, e} = cfgs[i];
      rt = 2'(rnd());
      for (int k = 0; k < 2; k++) begin
        cap[k] = p[k] ? cap_of(x[k], d[k], r[k]) : 64'h0;
      end
      tot = cap[0] + cap[1];
      flt = p == 2'h0 || (p & e) != 2'h0 || (p & x & r) != 2'h0;
      sp = !p[0];
      md = p != 2'h3 ? MODE_SINGLE : cap[0] == cap[1] ? MODE_SYM : MODE_ASYM;
      @(posedge clk);
      srst <= 1'b1;
      stall <= 2'h0;
      {ch_present, ch_x16, ch_dens_1g, ch_dual_rank} <= {p, x, d, r};
      ch_ecc_or_reg <= e;
      ch_rate_800 <= rt;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("reset state", {MODE_SINGLE, 5'h0},
        {mode_ff, cfg_done_ff, cfg_fault_ff, req_ack_ff,
        ch0_cmd_valid_ff, ch1_cmd_valid_ff});
      cfg_lock <= 1'b1;
      @(posedge clk);
      cfg_lock <= 1'b0;
      @(posedge clk);
      chk("lock result", {!flt, flt}, {cfg_done_ff, cfg_fault_ff});
      if (!flt) begin
        chk("mode", md, mode_ff);
        chk("rate", rt, rate_800_ff);
      end
      // A late second lock with other population must change nothing
      {ch_present, ch_x16, ch_dens_1g} <= 6'(rnd());
      cfg_lock <= 1'b1;
      @(posedge clk);
      cfg_lock <= 1'b0;
      if (flt) begin
        req_valid <= 1'b1;
        repeat (8) begin
          @(posedge clk);
          chk("refused ack", 0, req_ack_ff);
        end
        req_valid <= 1'b0;
      end else begin
        req(32'h0);
        req(32'(cap[0] - 1));
        req(32'(cap[0]));
        req(32'(tot - 1));
        req(32'(tot));
        repeat (24) req(32'(rnd() % (tot + (tot >> 3))));
        if (md == MODE_SYM) begin
          for (n = 0; n < 60 && (ch0_cmd_valid_ff || ch1_cmd_valid_ff);
              n++) begin
            @(posedge clk);
          end
          // Channel 0 stalls; the next line must still go to channel 1
          stall <= 2'h1;
          req(32'h1000);
          req(32'h1040);
          chk("first line held", 1, ch0_cmd_valid_ff);
          stall <= 2'h0;
        end
        chk("mode kept", md, mode_ff);
      end
    end
    end_sim();
  end

  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule
